// file: core/sig_seq_ctrl.sv
// Sequence numbering, acknowledgement and supervision for one path.
// Assumes synchronous one-cycle event pulses from the path machine.
`timescale 1ns/10ps
`default_nettype none
`include "sig_seq_regs.svh"
module sig_seq_ctrl
  import sig_seq_pkg::*;
#(
  parameter int TICK_DIV = `TICK_CYCLES,
  parameter int WAIT_TICKS = `ACK_WAIT_TICKS,
  parameter int DELAY_TICKS = `ACK_DELAY_TICKS
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Path machine events
  input wire logic LEAVE_IDLE,
  input wire logic SEND_MSG,
  input wire logic SEND_ACK_REQ,
  input wire logic RX_MSG,
  input wire logic [6:0] RX_MS,
  input wire logic RX_ACK,
  input wire logic [6:0] RX_MR,
  input wire logic RX_DISC,
  // Outgoing stamps
  output logic TX_MSG,
  output logic [6:0] TX_MS,
  output logic TX_ACK,
  output logic [6:0] TX_MR,
  output logic RX_ACCEPT,
  // Management and disconnect
  output logic ERR_IND,
  output logic DISC_REQ,
  // Status
  output logic [6:0] SEND_VAR,
  output logic [6:0] ACKED_VAR,
  output logic [6:0] RECV_VAR,
  output logic WAIT_RUNNING,
  output logic DELAY_RUNNING
);
  seq_t ss_q, sa_q, sr_q;
  seq_t ss_inc, outstanding, mr_off;
  logic tick;
  logic send_ok, send_ovf, ack_ok, ack_bad, rx_ok, rx_bad;
  logic wait_start, wait_stop, wait_exp;
  logic delay_start, delay_stop, delay_exp;
  logic ack_fire, fault;

  // Counter resolution 1 ms keeps both durations well inside 10 percent
  if (WAIT_TICKS < 1 || DELAY_TICKS < 1) begin : g_load_check
    $error("timer loads must be > 0");
  end
  if (TICK_DIV < 2) begin : g_div_check
    $error("TICK_DIV too small");
  end

  tick_divider #(.DIV(TICK_DIV)) u_div (
    .clk(CLK),
    .rst_n(RST_N),
    .tick(tick)
  );

  // Modulo 128 falls out of the seven-bit width
  assign ss_inc = ss_q + 7'h01;
  assign outstanding = ss_q - sa_q;
  assign mr_off = RX_MR - sa_q;
  // Send past the outstanding limit is a fault
  assign send_ovf = SEND_MSG && (outstanding >= `SEQ_MAX_OUTSTANDING);
  assign send_ok = SEND_MSG && !send_ovf;
  assign ack_ok = RX_ACK && (mr_off <= outstanding);
  assign ack_bad = RX_ACK && !ack_ok;
  assign rx_ok = RX_MSG && (RX_MS == sr_q);
  assign rx_bad = RX_MSG && !rx_ok;
  assign fault = send_ovf || ack_bad || rx_bad || wait_exp;
  // Acknowledgement goes out on request or on delay expiry
  assign ack_fire = (SEND_ACK_REQ || delay_exp) && !fault;

  // Sequence variables, cleared on leaving idle
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ss_q <= `SEQ_RESET;
      sa_q <= `SEQ_RESET;
      sr_q <= `SEQ_RESET;
    end else if (LEAVE_IDLE) begin
      ss_q <= `SEQ_RESET;
      sa_q <= `SEQ_RESET;
      sr_q <= `SEQ_RESET;
    end else begin
      if (send_ok) ss_q <= ss_inc;
      if (ack_ok) sa_q <= RX_MR;
      if (rx_ok) sr_q <= sr_q + 7'h01;
    end
  end

  // Outgoing stamps
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      TX_MSG <= 1'b0;
      TX_MS <= `SEQ_RESET;
      TX_ACK <= 1'b0;
      TX_MR <= `SEQ_RESET;
      RX_ACCEPT <= 1'b0;
    end else begin
      TX_MSG <= send_ok;
      if (send_ok) TX_MS <= ss_q;
      TX_ACK <= ack_fire;
      if (ack_fire) TX_MR <= sr_q;
      RX_ACCEPT <= rx_ok;
    end
  end

  // Error indication and disconnect
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ERR_IND <= 1'b0;
      DISC_REQ <= 1'b0;
    end else begin
      ERR_IND <= fault;
      DISC_REQ <= fault;
    end
  end

  // Wait timer control
  // A send in the all-acked cycle still needs supervision
  assign wait_stop = fault || RX_DISC || LEAVE_IDLE
                     || (ack_ok && RX_MR == ss_q && !send_ok);
  assign wait_start = !wait_stop && ((send_ok && !WAIT_RUNNING)
                     || (send_ok && ack_ok && RX_MR == ss_q)
                     || (ack_ok && RX_MR != ss_q));
  // Delay timer control
  assign delay_stop = fault || RX_DISC || LEAVE_IDLE || ack_fire;
  assign delay_start = rx_ok && !DELAY_RUNNING && !delay_stop;

  // One instance per path keeps timers independent
  sup_timer #(.LOAD(WAIT_TICKS)) u_wait (
    .clk(CLK),
    .rst_n(RST_N),
    .tick(tick),
    .start(wait_start),
    .stop(wait_stop),
    .running(WAIT_RUNNING),
    .expired(wait_exp)
  );

  sup_timer #(.LOAD(DELAY_TICKS)) u_delay (
    .clk(CLK),
    .rst_n(RST_N),
    .tick(tick),
    .start(delay_start),
    .stop(delay_stop),
    .running(DELAY_RUNNING),
    .expired(delay_exp)
  );

  assign SEND_VAR = ss_q;
  assign ACKED_VAR = sa_q;
  assign RECV_VAR = sr_q;

  a_leave_idle_clear: assert property (@(posedge CLK) disable iff (!RST_N)
    LEAVE_IDLE |=> (ss_q == 7'h00 && sa_q == 7'h00 && sr_q == 7'h00))
    else $error("variables not cleared on leaving idle");
  a_send_stamp: assert property (@(posedge CLK) disable iff (!RST_N)
    (send_ok && !LEAVE_IDLE) |=> (TX_MSG && TX_MS == $past(ss_q)
    && ss_q == $past(ss_q) + 7'h01))
    else $error("send stamp or increment wrong");
  a_outstanding_cap: assert property (@(posedge CLK) disable iff (!RST_N)
    (SEND_MSG && (ss_q - sa_q) == 7'h7f && !LEAVE_IDLE) |=>
    (!TX_MSG && ERR_IND && DISC_REQ && SEND_VAR == $past(ss_q)))
    else $error("outstanding limit broken");
  a_overflow_stop: assert property (@(posedge CLK) disable iff (!RST_N)
    (SEND_MSG && (ss_q - sa_q) == 7'h7f) |=>
    (!WAIT_RUNNING && !DELAY_RUNNING))
    else $error("timers not stopped on overflow");
  a_wait_first: assert property (@(posedge CLK) disable iff (!RST_N)
    (SEND_MSG && !WAIT_RUNNING && (ss_q - sa_q) != 7'h7f && !fault
    && !RX_DISC && !LEAVE_IDLE) |=> WAIT_RUNNING)
    else $error("wait timer not started on send");
  a_bad_ack_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    (RX_ACK && (RX_MR - sa_q) > (ss_q - sa_q) && !LEAVE_IDLE) |=>
    (ACKED_VAR == $past(sa_q) && ERR_IND && DISC_REQ))
    else $error("invalid ack not refused");
  a_rx_bad: assert property (@(posedge CLK) disable iff (!RST_N)
    (RX_MSG && RX_MS != sr_q && !LEAVE_IDLE) |=>
    (!RX_ACCEPT && ERR_IND && RECV_VAR == $past(sr_q)))
    else $error("out-of-sequence message not refused");
  a_delay_start: assert property (@(posedge CLK) disable iff (!RST_N)
    (RX_MSG && RX_MS == sr_q && !DELAY_RUNNING && !fault && !SEND_ACK_REQ
    && !RX_DISC && !LEAVE_IDLE) |=> DELAY_RUNNING)
    else $error("delay timer not started");
  a_ack_stops_delay: assert property (@(posedge CLK) disable iff (!RST_N)
    TX_ACK |-> !DELAY_RUNNING)
    else $error("delay timer runs after ack");
  a_leave_stops: assert property (@(posedge CLK) disable iff (!RST_N)
    LEAVE_IDLE |=> (!WAIT_RUNNING && !DELAY_RUNNING))
    else $error("timers not stopped on leaving idle");
  a_ack_restart: assert property (@(posedge CLK) disable iff (!RST_N)
    (RX_ACK && RX_MR != ss_q && (RX_MR - sa_q) <= (ss_q - sa_q) && !fault
    && !RX_DISC && !LEAVE_IDLE) |=> WAIT_RUNNING)
    else $error("wait timer not restarted");
  a_fault_report: assert property (@(posedge CLK) disable iff (!RST_N)
    (ack_bad || rx_bad || send_ovf) |=> (ERR_IND && DISC_REQ)
    ##1 (!WAIT_RUNNING && !DELAY_RUNNING))
    else $error("fault not reported");
  a_rx_accept: assert property (@(posedge CLK) disable iff (!RST_N)
    (RX_MSG && RX_MS == sr_q && !LEAVE_IDLE) |=>
    (RX_ACCEPT && sr_q == $past(sr_q) + 7'h01))
    else $error("in-sequence message not accepted");
  a_ack_stamp: assert property (@(posedge CLK) disable iff (!RST_N)
    ack_fire |=> (TX_ACK && TX_MR == $past(sr_q)) ##1 !DELAY_RUNNING)
    else $error("ack stamp wrong");
  a_delay_expiry: assert property (@(posedge CLK) disable iff (!RST_N)
    (delay_exp && !fault) |=> TX_ACK)
    else $error("delay expiry did not send ack");
  a_wait_expiry: assert property (@(posedge CLK) disable iff (!RST_N)
    wait_exp |=> (ERR_IND && DISC_REQ) ##1 !DELAY_RUNNING)
    else $error("wait expiry not handled");
  a_disc_stops: assert property (@(posedge CLK) disable iff (!RST_N)
    RX_DISC |=> ##1 (!WAIT_RUNNING && !DELAY_RUNNING))
    else $error("disconnect did not stop timers");
  a_all_acked: assert property (@(posedge CLK) disable iff (!RST_N)
    (ack_ok && RX_MR == ss_q && !RX_DISC && !SEND_MSG) |=>
    (!SEND_MSG ##1 !WAIT_RUNNING))
    else $error("wait timer not stopped when all acked");

  c_send: cover property (@(posedge CLK) disable iff (!RST_N) send_ok);
  c_ack_valid: cover property (@(posedge CLK) disable iff (!RST_N) ack_ok);
  c_delay_exp: cover property (@(posedge CLK) disable iff (!RST_N) delay_exp);
  c_wait_exp: cover property (@(posedge CLK) disable iff (!RST_N) wait_exp);
  c_rx_bad: cover property (@(posedge CLK) disable iff (!RST_N) rx_bad);
endmodule
`default_nettype wire

// file: core/sig_seq_pkg.sv
// Types for the signalling sequence and acknowledgement block.
// Assumes the constants header is compiled alongside.
package sig_seq_pkg;
  typedef logic [6:0] seq_t;
  typedef enum logic [2:0] {
    FAULT_NONE = 3'h1,
    FAULT_OVERFLOW = 3'h2,
    FAULT_SEQ = 3'h4
  } fault_dummy_t;
  typedef enum logic [1:0] {
    TMR_IDLE = 2'h1,
    TMR_RUN = 2'h2
  } tmr_state_t;
endpackage

// file: core/sig_seq_regs.svh
// Constants for the signalling sequence and acknowledgement block.
// Assumes a 200 MHz system clock; included by bare name.
`ifndef SIG_SEQ_REGS_SVH
`define SIG_SEQ_REGS_SVH

`define SEQ_W 7
`define SEQ_MOD 128
`define SEQ_MAX_OUTSTANDING 7'h7f
`define SEQ_RESET 7'h00
`define CLK_PERIOD_NS 5
`define TICK_PERIOD_NS 1000000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define TICKS_PER_S 1000
`define ACK_WAIT_S 10
`define ACK_DELAY_S 5
`define ACK_WAIT_TICKS (`ACK_WAIT_S * `TICKS_PER_S)
`define ACK_DELAY_TICKS (`ACK_DELAY_S * `TICKS_PER_S)

`endif

// file: core/sup_timer.sv
// Down-counting supervision timer on a tick enable.
// Assumes start, stop and tick are synchronous one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
module sup_timer
  import sig_seq_pkg::*;
#(
  parameter int LOAD = 10000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic start,
  input wire logic stop,
  output logic running,
  output logic expired
);
  localparam int CW = $clog2(LOAD + 1);
  tmr_state_t st_q;
  logic [CW-1:0] cnt_q;

  if (LOAD < 1) begin : g_load_check
    $error("sup_timer: LOAD must be positive");
  end

  assign running = (st_q == TMR_RUN);

  // Start wins over stop, so a restart in the same cycle reloads
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= TMR_IDLE;
      cnt_q <= '0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      unique case (st_q)
        TMR_IDLE: begin
          if (start) begin
            st_q <= TMR_RUN;
            cnt_q <= CW'(LOAD);
          end
        end
        TMR_RUN: begin
          if (start) begin
            cnt_q <= CW'(LOAD);
          end else if (stop) begin
            st_q <= TMR_IDLE;
          end else if (tick) begin
            if (cnt_q == CW'(1)) begin
              st_q <= TMR_IDLE;
              expired <= 1'b1;
            end else begin
              cnt_q <= cnt_q - 1'b1;
            end
          end
        end
        default: st_q <= TMR_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: core/tick_divider.sv
// Prescaler producing a one-cycle tick enable.
// Assumes one synchronous clock and synchronous active low reset.
`timescale 1ns/10ps
`default_nettype none
module tick_divider #(
  parameter int DIV = 200000
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);
  localparam int CW = $clog2(DIV);
  logic [CW-1:0] cnt_q;

  // Refused at elaboration: a divide below two gives no pulse
  if (DIV < 2) begin : g_div_check
    $error("tick_divider: DIV too small");
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (cnt_q == CW'(DIV - 1)) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else begin
      tick <= (cnt_q == CW'(DIV - 1));
    end
  end
endmodule
`default_nettype wire

// file: dv/peer_model.sv
// Peer entity model that acknowledges stamped signalling messages.
// Assumes the controller's registered one-cycle send pulses.
`timescale 1ns/10ps
`default_nettype none
module peer_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Controller side
  input wire logic tx_msg,
  input wire logic [6:0] tx_ms,
  output logic rx_ack,
  output logic [6:0] rx_mr,
  // Bench control
  input wire logic auto_ack,
  input wire logic [3:0] lat,
  input wire logic frc,
  input wire logic [6:0] frc_mr
);
  logic [3:0] wait_q;
  logic [6:0] mr_q;
  always_ff @(posedge clk) begin
    rx_ack <= 1'b0;
    // Idle field toggles so no stale number is ever read
    rx_mr <= ~rx_mr;
    if (!rst_n) begin
      wait_q <= 4'h0;
      mr_q <= 7'h00;
      rx_mr <= 7'h00;
    end else if (frc) begin
      rx_ack <= 1'b1;
      rx_mr <= frc_mr;
    end else if (tx_msg && auto_ack) begin
      wait_q <= lat;
      mr_q <= tx_ms + 7'h01;
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
      if (wait_q == 4'h1) begin
        rx_ack <= 1'b1;
        rx_mr <= mr_q;
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/sig_seq_ctrl_tb.sv
// Self-checking bench for the sequence and acknowledgement block.
// Assumes shortened tick and timer parameters for simulation.
`timescale 1ns/10ps
`default_nettype none
module sig_seq_ctrl_tb;
  localparam int TD = 4;
  localparam int WT = 100;
  localparam int DT = 5;
  logic CLK, RST_N, LEAVE_IDLE, SEND_MSG, SEND_ACK_REQ, RX_MSG;
  logic RX_ACK, RX_DISC, TX_MSG, TX_ACK, RX_ACCEPT, ERR_IND, DISC_REQ;
  logic WAIT_RUNNING, DELAY_RUNNING, auto_ack, frc;
  logic [6:0] RX_MS, RX_MR, TX_MS, TX_MR, SEND_VAR, ACKED_VAR, RECV_VAR;
  logic [6:0] frc_mr;
  int bad_count = 0;
  int total_checks = 0;
  sig_seq_ctrl #(.TICK_DIV(TD), .WAIT_TICKS(WT), .DELAY_TICKS(DT)) i_dut (
    .CLK(CLK), .RST_N(RST_N), .LEAVE_IDLE(LEAVE_IDLE),
    .SEND_MSG(SEND_MSG), .SEND_ACK_REQ(SEND_ACK_REQ), .RX_MSG(RX_MSG),
    .RX_MS(RX_MS), .RX_ACK(RX_ACK), .RX_MR(RX_MR), .RX_DISC(RX_DISC),
    .TX_MSG(TX_MSG), .TX_MS(TX_MS), .TX_ACK(TX_ACK), .TX_MR(TX_MR),
    .RX_ACCEPT(RX_ACCEPT), .ERR_IND(ERR_IND), .DISC_REQ(DISC_REQ),
    .SEND_VAR(SEND_VAR), .ACKED_VAR(ACKED_VAR), .RECV_VAR(RECV_VAR),
    .WAIT_RUNNING(WAIT_RUNNING), .DELAY_RUNNING(DELAY_RUNNING));
  peer_model i_peer (.clk(CLK), .rst_n(RST_N), .tx_msg(TX_MSG),
    .tx_ms(TX_MS), .rx_ack(RX_ACK), .rx_mr(RX_MR), .auto_ack(auto_ack),
    .lat(4'h2), .frc(frc), .frc_mr(frc_mr));
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  task automatic print_verdict();
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  // One event pulse; returns where its answer is visible
  task automatic ev(input int k, input logic [6:0] v);
    @(posedge CLK) begin
      case (k)
        0: LEAVE_IDLE <= 1'b1;
        1: SEND_MSG <= 1'b1;
        2: SEND_ACK_REQ <= 1'b1;
        3: RX_MSG <= 1'b1;
        4: RX_DISC <= 1'b1;
        default: frc <= 1'b1;
      endcase
      RX_MS <= v;
      frc_mr <= v;
    end
    @(posedge CLK) {LEAVE_IDLE, SEND_MSG, SEND_ACK_REQ} <= 3'h0;
    {RX_MSG, RX_DISC, frc} <= 3'h0;
    RX_MS <= ~v;
    if (k == 5) @(posedge CLK);
    #1;
  endtask
  // Wait for a pulse under a bound, then check its delay
  task automatic wait_dly(input int lo, input int hi, input bit ack);
    int n;
    n = 0;
    while ((ack ? TX_ACK : ERR_IND) !== 1'b1 && n < hi + 20) begin
      tick(1);
      n++;
    end
    chk(n >= lo && n <= hi, 1);
  endtask
  task automatic t_send();
    ev(1, 0);
    chk(TX_MSG, 1);
    chk(TX_MS, 0);
    chk(SEND_VAR, 1);
    chk(WAIT_RUNNING, 1);
    tick(5);
    chk(ACKED_VAR, 1);
    chk(WAIT_RUNNING, 0);
  endtask
  task automatic t_ack_check();
    auto_ack = 1'b0;
    @(posedge CLK) SEND_MSG <= 1'b1;
    @(posedge CLK);
    @(posedge CLK) SEND_MSG <= 1'b0;
    #1;
    chk(TX_MS, 2);
    chk(SEND_VAR, 3);
    ev(5, 2);
    chk(ACKED_VAR, 2);
    chk(WAIT_RUNNING, 1);
    ev(5, 1);
    chk({ERR_IND, DISC_REQ}, 3);
    chk(ACKED_VAR, 2);
    tick(1);
    chk({WAIT_RUNNING, ERR_IND}, 0);
    ev(5, 5);
    chk(ERR_IND, 1);
  endtask
  task automatic t_rx();
    ev(3, 0);
    chk({RX_ACCEPT, DELAY_RUNNING}, 3);
    chk(RECV_VAR, 1);
    ev(2, 0);
    chk(TX_ACK, 1);
    chk(TX_MR, 1);
    tick(1);
    chk(DELAY_RUNNING, 0);
    ev(3, 1);
    wait_dly(DT * TD * 9 / 10 - TD, DT * TD * 11 / 10 + TD + 2, 1);
    chk(TX_MR, 2);
    tick(1);
    chk(DELAY_RUNNING, 0);
    ev(3, 2);
    ev(3, 9);
    chk({ERR_IND, DISC_REQ, RX_ACCEPT}, 6);
    chk(RECV_VAR, 3);
    tick(1);
    chk(DELAY_RUNNING, 0);
  endtask
  task automatic t_disc_wait();
    ev(1, 0);
    ev(3, 3);
    chk({WAIT_RUNNING, DELAY_RUNNING}, 3);
    ev(4, 0);
    tick(1);
    chk({WAIT_RUNNING, DELAY_RUNNING}, 0);
    ev(1, 0);
    wait_dly(WT * TD * 9 / 10 - TD, WT * TD * 11 / 10 + TD + 2, 0);
    chk(DISC_REQ, 1);
  endtask
  task automatic t_limit();
    ev(0, 0);
    chk(SEND_VAR, 0);
    chk(ACKED_VAR, 0);
    chk(RECV_VAR, 0);
    @(posedge CLK) SEND_MSG <= 1'b1;
    repeat (127) @(posedge CLK);
    SEND_MSG <= 1'b0;
    #1;
    chk(SEND_VAR, 127);
    ev(1, 0);
    chk({TX_MSG, ERR_IND, DISC_REQ}, 3);
    chk(SEND_VAR, 127);
    tick(1);
    chk(WAIT_RUNNING, 0);
    ev(5, 127);
    chk(ACKED_VAR, 127);
    ev(1, 0);
    chk(TX_MS, 127);
    chk(SEND_VAR, 0);
  endtask
  initial begin
    {RST_N, LEAVE_IDLE, SEND_MSG, SEND_ACK_REQ, RX_MSG, RX_DISC} = 6'h00;
    {frc, RX_MS, frc_mr} = 15'h0000;
    auto_ack = 1'b1;
    repeat (10) @(posedge CLK);
    RST_N <= 1'b1;
    ev(0, 0);
    t_send();
    t_ack_check();
    t_rx();
    t_disc_wait();
    t_limit();
    print_verdict();
  end
  // Run needs about 650 cycles
  initial begin
    #100000;
    bad_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
